/* File: rtl/asx_regs.svh */
// Timing constants and pin field layout for the async SRAM host controller
`ifndef ASX_REGS_SVH
`define ASX_REGS_SVH
`define ASX_CLK_PS        25000
`define ASX_T_SD_PS       7000
`define ASX_T_AW_PS       9000
`define ASX_T_BW_PS       9000
`define ASX_T_HZWE_PS     7000
`define ASX_T_AA_PS       12000
`define ASX_T_DOE_PS      7000
`define ASX_T_POWER_US    100
`define ASX_CYC_MIN(ps)   (((ps) + `ASX_CLK_PS - 1) / `ASX_CLK_PS)
`define ASX_WR_CYC  ((`ASX_CYC_MIN(`ASX_T_AW_PS) > `ASX_CYC_MIN(`ASX_T_HZWE_PS + `ASX_T_SD_PS)) ? \
  `ASX_CYC_MIN(`ASX_T_AW_PS) : `ASX_CYC_MIN(`ASX_T_HZWE_PS + `ASX_T_SD_PS))
`define ASX_RD_CYC  (`ASX_CYC_MIN(`ASX_T_AA_PS) + 2)
`define ASX_POWER_CYC ((`ASX_T_POWER_US * 1000000 + `ASX_CLK_PS - 1) / `ASX_CLK_PS)
`define ASX_DATA_W  16
`define ASX_ADDR_W  22
`endif

/* File: rtl/asx_pkg.sv */
// Types for the async SRAM host controller
package asx_pkg;
  typedef enum logic [2:0] {
    ASX_POWERUP = 3'h0,
    ASX_IDLE    = 3'h1,
    ASX_WR_SET  = 3'h2,
    ASX_WR_ACT  = 3'h3,
    ASX_WR_END  = 3'h4,
    ASX_RD_SET  = 3'h5,
    ASX_RD_ACT  = 3'h6,
    ASX_RETAIN  = 3'h7
  } asx_state_t;
endpackage : asx_pkg

/* File: rtl/asx_sync2.sv */
// Two-flop synchroniser for the read data pins
`timescale 1ns/1ps
module asx_sync2 #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : asx_sync2

/* File: rtl/asx_host.sv */
// Host controller driving an asynchronous 16-bit static RAM through its pins
// Contract
// [R1] Selected only when low select low, high select high
// [R2] Write needs select, strobe low, a lane low
// [R3] Data timing measured from write-ending edge
// [R4] Write data stable 7 ns before end
// [R5] Address stable 9 ns before end, held after
// [R6] Lane selects asserted 9 ns before end
// [R7] Read data valid 12 ns after address
// [R8] Old read data held 3 ns after address change
// [R9] Data valid 7 ns after output gate low
// [R10] Lane data valid 7 ns after lane select
// [R11] Device floats when gate or lane high
// [R12] Joint select and strobe release keeps float
// [R13] Strobe write lasts float time plus setup
// [R14] Wait 100 us after power before access
// [R15] Deselect device before data retention
// [R16] Device floats while deselected or writing
// [R17] Release host drivers before enabling outputs
`timescale 1ns/1ps
`include "asx_regs.svh"
module asx_host
  import asx_pkg::*;
#(
  parameter int POWER_CYC = `ASX_POWER_CYC,
  parameter int DW        = `ASX_DATA_W,
  parameter int AW        = `ASX_ADDR_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rstn,
  // User request
  input  wire logic          req,
  input  wire logic          req_write,
  input  wire logic [AW-1:0] req_addr,
  input  wire logic [DW-1:0] req_wdata,
  input  wire logic [1:0]    req_lane_n,
  input  wire logic          retain_req,
  output logic               ready,
  output logic               rdata_valid,
  output logic [DW-1:0]      rdata,
  output logic               retain_ok,
  // Memory pins
  output logic [AW-1:0]      mem_addr,
  output logic               select_active_low,
  output logic               select_active_high,
  output logic               write_strobe_n,
  output logic               out_gate_n,
  output logic               lower_byte_lane_sel,
  output logic               upper_byte_lane_sel,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe_n,
  input  wire logic [DW-1:0] dq_in
);
  localparam int WR_CYC = `ASX_WR_CYC;
  localparam int RD_CYC = `ASX_RD_CYC;
  localparam int CW     = 22;

  typedef struct packed {
    asx_state_t    st;
    logic [CW-1:0] cnt;
    logic          ready;
    logic          rvalid;
    logic [DW-1:0] rdata;
    logic          rok;
    logic [AW-1:0] addr;
    logic          sel_n;
    logic          sel_h;
    logic          we_n;
    logic          oe_n;
    logic          lb_n;
    logic          ub_n;
    logic [DW-1:0] dout;
    logic          doe_n;
  } asx_regs_t;

  asx_regs_t    s_r, s_nxt;
  logic [DW-1:0] dq_sync;

  asx_sync2 #(.W(DW)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .d    (dq_in),
    .q    (dq_sync)
  );

  function automatic logic [CW-1:0] cyc(input int n);
    cyc = CW'(n);
  endfunction : cyc

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    if (s_r.cnt != '0)
      s_nxt.cnt = s_r.cnt - cyc(1);
    case (s_r.st)
      ASX_POWERUP: begin
        // Any access before the supply settles is lost by the memory
        if (s_r.cnt == '0) begin // R14
          s_nxt.st    = ASX_IDLE;
          s_nxt.ready = 1'b1;
        end
      end
      ASX_IDLE: begin
        s_nxt.rok = 1'b0;
        if (retain_req) begin
          s_nxt.st    = ASX_RETAIN;
          s_nxt.ready = 1'b0;
          s_nxt.sel_n = 1'b1; // R15
          s_nxt.sel_h = 1'b0; // R1
        end else if (req) begin
          s_nxt.ready = 1'b0;
          s_nxt.addr  = req_addr;
          s_nxt.lb_n  = req_lane_n[0];
          s_nxt.ub_n  = req_lane_n[1];
          s_nxt.sel_n = 1'b0; // R1
          s_nxt.sel_h = 1'b1; // R1
          if (req_write) begin
            // Address, lanes and data settle a cycle before the strobe falls
            s_nxt.st    = ASX_WR_SET; // R5
            s_nxt.oe_n  = 1'b1;
            s_nxt.dout  = req_wdata;
            s_nxt.doe_n = 1'b0;
          end else begin
            s_nxt.st    = ASX_RD_SET;
            s_nxt.doe_n = 1'b1; // R17
          end
        end
      end
      ASX_WR_SET: begin
        s_nxt.st   = ASX_WR_ACT;
        s_nxt.we_n = 1'b0; // R2
        s_nxt.cnt  = cyc(WR_CYC - 1);
      end
      ASX_WR_ACT: begin
        // Strobe alone ends the write; select stays so no joint release
        if (s_r.cnt == '0) begin // R4 R6 R13
          s_nxt.st   = ASX_WR_END;
          s_nxt.we_n = 1'b1; // R3
        end
      end
      ASX_WR_END: begin
        // Address and data held one cycle past the ending edge
        s_nxt.st    = ASX_IDLE; // R5
        s_nxt.doe_n = 1'b1;
        s_nxt.sel_n = 1'b1;
        s_nxt.sel_h = 1'b0;
        s_nxt.lb_n  = 1'b1;
        s_nxt.ub_n  = 1'b1;
        s_nxt.ready = 1'b1;
      end
      ASX_RD_SET: begin
        s_nxt.st   = ASX_RD_ACT;
        s_nxt.oe_n = 1'b0; // R17
        s_nxt.cnt  = cyc(RD_CYC);
      end
      ASX_RD_ACT: begin
        // Wait covers access time plus the two synchroniser stages
        if (s_r.cnt == '0) begin // R7 R9 R10
          s_nxt.st     = ASX_IDLE;
          s_nxt.rdata  = dq_sync;
          s_nxt.rvalid = 1'b1;
          s_nxt.ready  = 1'b1;
          s_nxt.oe_n   = 1'b1;
          s_nxt.sel_n  = 1'b1;
          s_nxt.sel_h  = 1'b0;
          s_nxt.lb_n   = 1'b1;
          s_nxt.ub_n   = 1'b1;
        end
      end
      ASX_RETAIN: begin
        s_nxt.rok = 1'b1; // R15
        if (!retain_req) begin
          s_nxt.st    = ASX_IDLE;
          s_nxt.rok   = 1'b0;
          s_nxt.ready = 1'b1;
        end
      end
      default: s_nxt.st = ASX_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_r       <= '0;
      s_r.st    <= ASX_POWERUP;
      s_r.cnt   <= cyc(POWER_CYC);
      s_r.sel_n <= 1'b1;
      s_r.we_n  <= 1'b1;
      s_r.oe_n  <= 1'b1;
      s_r.lb_n  <= 1'b1;
      s_r.ub_n  <= 1'b1;
      s_r.doe_n <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign ready               = s_r.ready;
  assign rdata_valid         = s_r.rvalid;
  assign rdata               = s_r.rdata;
  assign retain_ok           = s_r.rok;
  assign mem_addr            = s_r.addr;
  assign select_active_low   = s_r.sel_n;
  assign select_active_high  = s_r.sel_h;
  assign write_strobe_n      = s_r.we_n;
  assign out_gate_n          = s_r.oe_n;
  assign lower_byte_lane_sel = s_r.lb_n;
  assign upper_byte_lane_sel = s_r.ub_n;
  assign dq_out              = s_r.dout;
  assign dq_oe_n             = s_r.doe_n;

  ////////////////////////////////////////////////////////////////////////////
  chk_no_contention: assert property (@(posedge clk) disable iff (!rstn) // R17
    !(s_r.oe_n == 1'b0 && s_r.doe_n == 1'b0)) else $error("host and memory both drive");
  chk_write_len: assert property (@(posedge clk) disable iff (!rstn) // R13
    $rose(s_r.we_n) |-> $past(s_r.we_n, WR_CYC) == 1'b0 &&
      WR_CYC * `ASX_CLK_PS >= `ASX_T_HZWE_PS + `ASX_T_SD_PS)
    else $error("write strobe too short");
  chk_write_sel: assert property (@(posedge clk) disable iff (!rstn) // R2
    !s_r.we_n |-> (!s_r.sel_n && s_r.sel_h && !(s_r.lb_n && s_r.ub_n)))
    else $error("write without select or lane");
  chk_data_hold: assert property (@(posedge clk) disable iff (!rstn) // R4
    $rose(s_r.we_n) |-> !s_r.doe_n && $stable(s_r.dout) && $stable(s_r.addr))
    else $error("data or address moved at write end");
  chk_addr_setup: assert property (@(posedge clk) disable iff (!rstn) // R5
    $fell(s_r.we_n) |-> $stable(s_r.addr) && !s_r.sel_n)
    else $error("address not set up before write");
  chk_power_wait: assert property (@(posedge clk) disable iff (!rstn) // R14
    (s_r.st == ASX_POWERUP) |-> s_r.sel_n && !s_r.sel_h) else $error("access during power up");
  chk_retain_desel: assert property (@(posedge clk) disable iff (!rstn) // R15
    s_r.rok |-> s_r.sel_n && !s_r.sel_h) else $error("retention while selected");
  chk_joint_release: assert property (@(posedge clk) disable iff (!rstn) // R12
    $rose(s_r.we_n) |-> $stable(s_r.sel_n)) else $error("select released with strobe");
  // Gate low long enough to cover access time plus both synchroniser stages
  chk_read_pulse: assert property (@(posedge clk) disable iff (!rstn) // R7
    s_r.rvalid |-> ($past(s_r.oe_n, RD_CYC + 1) == 1'b0 &&
      RD_CYC * `ASX_CLK_PS >= `ASX_T_AA_PS + 2 * `ASX_CLK_PS) ##1 !s_r.rvalid)
    else $error("read taken too early or valid too long");
endmodule : asx_host

/* File: sim/asx_sram_model.sv */
// Behavioural 16-bit static RAM answering the host controller
`timescale 1ns/1ps
module asx_sram_model (
  // Memory pins
  input  wire logic [21:0] addr,
  input  wire logic        sel_n,
  input  wire logic        sel,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [1:0]  lane_n,
  input  wire logic [15:0] dq_w,
  output logic      [15:0] dq_r
);
  logic [15:0] mem [16];
  wire         cs = !sel_n && sel;
  wire         rd = cs && we_n && !oe_n;
  initial dq_r = 16'h0;
  ////////////////////////////////////////////////////////////////
  // Data lands as the strobe closes, lane by lane
  always @(posedge we_n) if (cs) begin
    if (!lane_n[0]) mem[addr[3:0]][7:0] <= dq_w[7:0];
    if (!lane_n[1]) mem[addr[3:0]][15:8] <= dq_w[15:8];
  end
  // Floating lanes toggle so a stray sample never passes by luck
  always #1 for (int b = 0; b < 2; b++)
    dq_r[b*8+:8] = (rd && !lane_n[b]) ? mem[addr[3:0]][b*8+:8] : ~dq_r[b*8+:8];
endmodule : asx_sram_model

/* File: sim/tb.sv */
// Self-checking bench for the async SRAM host controller
`timescale 1ns/1ps
module tb;
  logic        clk = 0, rstn = 0, req = 0, req_write = 0, retain_req = 0;
  logic [21:0] req_addr = 22'h0, mem_addr;
  logic [21:0] cur_addr = 22'h3;
  logic [15:0] req_wdata = 16'h0, rdata, dq_out, dq_in, got, expv;
  logic [1:0]  req_lane_n = 2'h3;
  logic        ready, rdata_valid, retain_ok, sel_n, sel, we_n, oe_n, lo_n, hi_n, dq_oe_n;
  int          mismatches = 0, num_checks = 0;
  localparam int F_READY  = 0;
  localparam int F_VALID  = 1;
  localparam int F_RETAIN = 2;
  initial forever #12.5 clk = ~clk;
  asx_host #(.POWER_CYC(10)) asx_host_inst (.clk(clk), .rstn(rstn), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_lane_n(req_lane_n), .retain_req(retain_req), .ready(ready),
    .rdata_valid(rdata_valid), .rdata(rdata), .retain_ok(retain_ok), .mem_addr(mem_addr),
    .select_active_low(sel_n), .select_active_high(sel), .write_strobe_n(we_n),
    .out_gate_n(oe_n), .lower_byte_lane_sel(lo_n), .upper_byte_lane_sel(hi_n),
    .dq_out(dq_out), .dq_oe_n(dq_oe_n), .dq_in(dq_in));
  // Released host drivers show the inverse so the model never sees stale data
  asx_sram_model asx_sram_model_inst (.addr(mem_addr), .sel_n(sel_n), .sel(sel),
    .we_n(we_n), .oe_n(oe_n), .lane_n({hi_n, lo_n}),
    .dq_w(dq_oe_n ? ~dq_out : dq_out), .dq_r(dq_in));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  function automatic logic flag(input int which);
    flag = (which == F_READY) ? ready : (which == F_VALID) ? rdata_valid : retain_ok;
  endfunction : flag
  task automatic wait_hi(input int which, input int lim);
    for (int n = 0; flag(which) !== 1'b1; n++) begin
      if (n == lim) begin
        mismatches++;
        $display("mismatch at %0t: wait ran out", $time);
        final_report();
      end
      @(negedge clk);
    end
  endtask : wait_hi
  task automatic access(input logic w, input logic [15:0] d, input logic [1:0] ln);
    wait_hi(F_READY, 40);
    req = 1;
    req_write = w;
    req_addr = cur_addr;
    req_wdata = d;
    req_lane_n = ln;
    @(negedge clk);
    req = 0;
    if (!w) begin
      wait_hi(F_VALID, 20);
      got = rdata;
    end
  endtask : access
  ////////////////////////////////////////////////////////////////
  // Pin discipline while the strobe or the output gate is low
  always @(negedge clk) if (rstn) begin
    if (!we_n) check({sel_n, sel, dq_oe_n, lo_n & hi_n}, 4'h4);
    if (!oe_n) check(dq_oe_n, 1'b1);
    if (!we_n || !oe_n) check(mem_addr == req_addr, 1'b1);
  end
  task automatic t_power();
    repeat (6) @(negedge clk);
    rstn = 1;
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      check(ready, 1'b0);
      check({sel_n, sel}, 2'h2);
    end
    wait_hi(F_READY, 10);
    $display("test power done");
  endtask : t_power
  task automatic t_lanes();
    logic [15:0] d;
    access(1, 16'ha55a, 2'h0);
    access(0, 16'h0, 2'h0);
    check(got, 16'ha55a);
    expv = 16'ha55a;
    // Both lanes, upper only, lower only
    for (int k = 0; k < 3; k++) begin
      d = 16'hc3c3 ^ 16'(k * 16'h1111);
      if (k != 1) expv[7:0] = d[7:0];
      if (k != 2) expv[15:8] = d[15:8];
      access(1, d, 2'(k));
      access(0, 16'h0, 2'h0);
      check(got, expv);
    end
    // A word at another address must not disturb the first
    cur_addr = 22'h2a5c07;
    access(1, 16'h1234, 2'h0);
    access(0, 16'h0, 2'h0);
    check(got, 16'h1234);
    cur_addr = 22'h3;
    access(0, 16'h0, 2'h0);
    check(got, expv);
    $display("test lanes done");
  endtask : t_lanes
  task automatic t_retain();
    wait_hi(F_READY, 40);
    retain_req = 1;
    wait_hi(F_RETAIN, 20);
    repeat (3) begin
      check({sel_n, sel, retain_ok}, 3'h5);
      @(negedge clk);
    end
    retain_req = 0;
    access(0, 16'h0, 2'h0);
    check(got, expv);
    $display("test retain done");
  endtask : t_retain
  initial begin
    t_power();
    t_lanes();
    t_retain();
    final_report();
  end
endmodule : tb
